// *** hw/byte_memory.sv ***
// 256 x 8 memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module byte_memory (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_we,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [256];

    // write port, no reset on the array itself
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
    end

    // read data from a register, one cycle behind the address
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= mem[i_addr];
        end
    end
endmodule
`default_nettype wire

// *** hw/optical_module_control_status.sv ***
// control, fault latch, rate selects and two-wire memory map of the optical module
`timescale 1ns/100ps
`default_nettype none
module optical_module_control_status (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_tx_off,
    input wire logic i_tx_rate_sel,
    input wire logic i_rx_rate_sel,
    input wire logic i_laser_fault_det,
    input wire logic i_receive_signal_lost_det,
    input wire optmod_pkg::monitors_t i_monitors,
    input wire logic i_scl,
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic o_laser_enable,
    output logic o_tx_cdr_engage,
    output logic o_rx_cdr_engage,
    output logic o_tx_fault_out,
    output logic o_tx_fault_oe,
    output logic o_receive_signal_lost
);
    ////////////////////////////////////////////////////////////////////////////
    optmod_pkg::pins_t pins_raw;
    optmod_pkg::pins_t pins_s;
    optmod_pkg::two_wire_state_t state_q;
    logic scl_prev_q, sda_prev_q, scl_rise, scl_fall, bus_start, bus_stop;
    logic [2:0] cnt_q;
    logic [7:0] shift_q, ptr_q, in_byte, rd_byte, status_byte, id_rd, diag_rd;
    logic sel_diag_q, rnw_q, ack_on_q, sda_oe_q, dev_match;
    logic wr_fire, id_we, diag_we, status_we;
    logic sw_off_q, fault_q, txoff_prev_q, txoff_rise;
    logic laser_en_q, tx_cdr_q, rx_cdr_q, fault_oe_q, rx_lost_q;

    function automatic logic is_monitor(input logic [7:0] a);
        return (a >= optmod_pkg::MON_FIRST) && (a <= optmod_pkg::MON_LAST);
    endfunction

    // pick one big-endian byte out of the live readings
    function automatic logic [7:0] monitor_byte(input optmod_pkg::monitors_t m, input logic [7:0] a);
        logic [7:0] k;
        logic [79:0] flat;
        k = a - optmod_pkg::MON_FIRST;
        flat = m;
        return flat[8'd79 - {k[4:0], 3'h0} -: 8];
    endfunction

    assign pins_raw = {i_tx_off, i_tx_rate_sel, i_rx_rate_sel, i_laser_fault_det,
                       i_receive_signal_lost_det, i_scl, i_sda_in};

    pin_sync u_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_pins(pins_raw),
        .o_pins(pins_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus edges and start/stop conditions, seen on synchronised levels only
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= pins_s.scl;
            sda_prev_q <= pins_s.sda;
        end
    end

    assign scl_rise = pins_s.scl & ~scl_prev_q;
    assign scl_fall = ~pins_s.scl & scl_prev_q;
    assign bus_start = pins_s.scl & scl_prev_q & sda_prev_q & ~pins_s.sda;
    assign bus_stop = pins_s.scl & scl_prev_q & ~sda_prev_q & pins_s.sda;
    assign in_byte = {shift_q[6:0], pins_s.sda};
    assign dev_match = (in_byte[7:1] == optmod_pkg::ID_DEV_ADDR) ||
                       (in_byte[7:1] == optmod_pkg::DIAG_DEV_ADDR);

    // live status byte, rebuilt every cycle so reads never go stale
    always_comb begin
        status_byte = 8'h00;
        status_byte[optmod_pkg::TXOFF_STATE_BIT] = pins_s.tx_off;
        status_byte[optmod_pkg::SW_TXOFF_BIT] = sw_off_q;
        status_byte[optmod_pkg::FAULT_BIT] = fault_q;
        status_byte[optmod_pkg::RX_LOST_BIT] = pins_s.rx_lost;
    end

    // read mux: live bytes override the diagnostic array
    always_comb begin
        if (!sel_diag_q) begin
            rd_byte = id_rd;
        end else if (ptr_q == optmod_pkg::STATUS_CTRL_OFFSET) begin
            rd_byte = status_byte;
        end else if (is_monitor(ptr_q)) begin
            rd_byte = monitor_byte(i_monitors, ptr_q);
        end else begin
            rd_byte = diag_rd;
        end
    end

    // write strobes; monitor bytes and read-only status bits ignore writes
    assign wr_fire = scl_rise && (state_q == optmod_pkg::ST_WR) && (cnt_q == optmod_pkg::LAST_BIT);
    assign id_we = wr_fire && !sel_diag_q;
    assign status_we = wr_fire && sel_diag_q && (ptr_q == optmod_pkg::STATUS_CTRL_OFFSET);
    assign diag_we = wr_fire && sel_diag_q && !status_we && !is_monitor(ptr_q);

    byte_memory u_id_mem (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_we(id_we),
        .i_addr(ptr_q),
        .i_wdata(in_byte),
        .o_rdata(id_rd)
    );

    byte_memory u_diag_mem (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_we(diag_we),
        .i_addr(ptr_q),
        .i_wdata(in_byte),
        .o_rdata(diag_rd)
    );

    ////////////////////////////////////////////////////////////////////////////
    // two-wire slave: sample on scl rise, change sda on scl fall
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_q <= optmod_pkg::ST_IDLE;
            cnt_q <= 3'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            sel_diag_q <= 1'b0;
            rnw_q <= 1'b0;
            ack_on_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (bus_start) begin
            state_q <= optmod_pkg::ST_DEV;
            cnt_q <= 3'h0;
            ack_on_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (bus_stop) begin
            state_q <= optmod_pkg::ST_IDLE;
            ack_on_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (scl_rise) begin
            unique case (state_q)
                optmod_pkg::ST_DEV, optmod_pkg::ST_WORD, optmod_pkg::ST_WR: begin
                    shift_q <= in_byte;
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == optmod_pkg::LAST_BIT) begin
                        if (state_q == optmod_pkg::ST_DEV) begin
                            state_q <= dev_match ? optmod_pkg::ST_DEV_ACK : optmod_pkg::ST_IDLE;
                            sel_diag_q <= (in_byte[7:1] == optmod_pkg::DIAG_DEV_ADDR);
                            rnw_q <= in_byte[0];
                        end else if (state_q == optmod_pkg::ST_WORD) begin
                            state_q <= optmod_pkg::ST_WORD_ACK;
                            ptr_q <= in_byte;
                        end else begin
                            state_q <= optmod_pkg::ST_WR_ACK;
                            ptr_q <= ptr_q + 8'h01;
                        end
                    end
                end
                optmod_pkg::ST_RD: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == optmod_pkg::LAST_BIT) begin
                        state_q <= optmod_pkg::ST_RD_ACK;
                    end
                end
                optmod_pkg::ST_RD_ACK: begin
                    // master not-acknowledge ends the read
                    state_q <= pins_s.sda ? optmod_pkg::ST_IDLE : optmod_pkg::ST_RD_LOAD;
                end
                optmod_pkg::ST_IDLE, optmod_pkg::ST_DEV_ACK, optmod_pkg::ST_WORD_ACK,
                optmod_pkg::ST_WR_ACK, optmod_pkg::ST_RD_LOAD: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (state_q)
                optmod_pkg::ST_DEV_ACK, optmod_pkg::ST_WORD_ACK, optmod_pkg::ST_WR_ACK: begin
                    if (!ack_on_q) begin
                        ack_on_q <= 1'b1;
                        sda_oe_q <= 1'b1; // pull sda low for acknowledge
                    end else begin
                        ack_on_q <= 1'b0;
                        cnt_q <= 3'h0;
                        if (state_q == optmod_pkg::ST_DEV_ACK && rnw_q) begin
                            state_q <= optmod_pkg::ST_RD;
                            shift_q <= rd_byte;
                            sda_oe_q <= ~rd_byte[7];
                            ptr_q <= ptr_q + 8'h01;
                        end else begin
                            state_q <= (state_q == optmod_pkg::ST_DEV_ACK) ? optmod_pkg::ST_WORD : optmod_pkg::ST_WR;
                            sda_oe_q <= 1'b0;
                        end
                    end
                end
                optmod_pkg::ST_RD: begin
                    shift_q <= {shift_q[6:0], 1'b0};
                    sda_oe_q <= ~shift_q[6];
                end
                optmod_pkg::ST_RD_ACK: begin
                    sda_oe_q <= 1'b0; // release for master acknowledge
                end
                optmod_pkg::ST_RD_LOAD: begin
                    state_q <= optmod_pkg::ST_RD;
                    cnt_q <= 3'h0;
                    shift_q <= rd_byte;
                    sda_oe_q <= ~rd_byte[7];
                    ptr_q <= ptr_q + 8'h01;
                end
                optmod_pkg::ST_IDLE, optmod_pkg::ST_DEV, optmod_pkg::ST_WORD, optmod_pkg::ST_WR: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software transmit-off bit, the only writable status bit
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sw_off_q <= optmod_pkg::SW_TXOFF_RESET;
        end else if (status_we) begin
            sw_off_q <= in_byte[optmod_pkg::SW_TXOFF_BIT];
        end
    end

    assign txoff_rise = pins_s.tx_off & ~txoff_prev_q;

    // fault latch; a new fault beats a clearing toggle in the same cycle
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            fault_q <= 1'b0;
            txoff_prev_q <= 1'b1;
        end else begin
            txoff_prev_q <= pins_s.tx_off;
            if (pins_s.fault_det) begin
                fault_q <= 1'b1;
            end else if (txoff_rise) begin
                fault_q <= 1'b0;
            end
        end
    end

    // output flops; laser held off from reset until the pin is seen low
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            laser_en_q <= 1'b0;
            tx_cdr_q <= 1'b0;
            rx_cdr_q <= 1'b0;
            fault_oe_q <= 1'b1;
            rx_lost_q <= 1'b0;
        end else begin
            laser_en_q <= ~(pins_s.tx_off | sw_off_q | fault_q | pins_s.fault_det);
            tx_cdr_q <= pins_s.tx_rate;
            rx_cdr_q <= pins_s.rx_rate;
            fault_oe_q <= ~(fault_q | pins_s.fault_det);
            rx_lost_q <= pins_s.rx_lost;
        end
    end

    assign o_sda_out = optmod_pkg::SDA_LEVEL_DRIVEN;
    assign o_sda_oe = sda_oe_q;
    assign o_laser_enable = laser_en_q;
    assign o_tx_cdr_engage = tx_cdr_q;
    assign o_rx_cdr_engage = rx_cdr_q;
    assign o_tx_fault_out = optmod_pkg::SDA_LEVEL_DRIVEN;
    assign o_tx_fault_oe = fault_oe_q;
    assign o_receive_signal_lost = rx_lost_q;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_addr_byte_done;
        (state_q == optmod_pkg::ST_DEV) && scl_rise && (cnt_q == optmod_pkg::LAST_BIT) && dev_match;
    endsequence

    sequence s_ack_driven;
        (state_q == optmod_pkg::ST_DEV_ACK) && sda_oe_q;
    endsequence

    AST_ADDR_ACK: assert property (s_addr_byte_done |-> ##[1:1000] s_ack_driven)
        else $error("matched address not acknowledged");
    AST_LASER_OFF: assert property ((pins_s.tx_off || sw_off_q || fault_q) |=> !o_laser_enable)
        else $error("laser enabled while an off source is set");
    AST_LASER_ON: assert property (!pins_s.tx_off && !sw_off_q && !fault_q && !pins_s.fault_det
                                   |=> o_laser_enable)
        else $error("laser off with no off source");
    AST_RATES_INDEP: assert property ((pins_s.tx_rate != pins_s.rx_rate)
                                      |=> (o_tx_cdr_engage != o_rx_cdr_engage))
        else $error("rate selects not independent");
    AST_TX_CDR: assert property ($rose(pins_s.tx_rate) |=> o_tx_cdr_engage)
        else $error("transmit recovery stage not engaged");
    AST_RX_CDR: assert property ($fell(pins_s.rx_rate) |=> !o_rx_cdr_engage)
        else $error("receive recovery stage not bypassed");
    AST_FAULT_HOLD: assert property (fault_q && !txoff_rise |=> fault_q [*1] ##0 !o_tx_fault_oe)
        else $error("fault latch dropped without toggle");
    AST_FAULT_CLEAR: assert property (fault_q && txoff_rise && !pins_s.fault_det |=> !fault_q)
        else $error("toggle did not clear fault");
    AST_FAULT_SET: assert property (pins_s.fault_det |=> fault_q && !o_laser_enable && !o_tx_fault_oe)
        else $error("fault not latched or laser not disabled");
    AST_STATUS_LIVE: assert property ((sel_diag_q && ptr_q == optmod_pkg::STATUS_CTRL_OFFSET)
                                      |-> rd_byte == {pins_s.tx_off, sw_off_q, 3'h0, fault_q, pins_s.rx_lost, 1'b0})
        else $error("status byte not tracking live state");
    AST_RX_LOST_PIN: assert property ($changed(pins_s.rx_lost)
                                      |=> o_receive_signal_lost == $past(pins_s.rx_lost))
        else $error("loss-of-signal pin wrong");
    AST_SW_ONLY: assert property (!status_we |=> $stable(sw_off_q))
        else $error("software off bit changed without a write");
endmodule
`default_nettype wire

// *** hw/optmod_pkg.sv ***
// shared constants and types of the optical module control and status logic
package optmod_pkg;
    // two-wire device addresses, 7-bit form of the 0xA0 and 0xA2 bytes
    localparam logic [6:0] ID_DEV_ADDR = 7'h50;
    localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;
    // diagnostic space offsets
    localparam logic [7:0] STATUS_CTRL_OFFSET = 8'h6E;
    localparam logic [7:0] MON_FIRST = 8'h60;
    localparam logic [7:0] MON_LAST = 8'h69;
    // status_control_byte field positions
    localparam int TXOFF_STATE_BIT = 7;
    localparam int SW_TXOFF_BIT = 6;
    localparam int FAULT_BIT = 2;
    localparam int RX_LOST_BIT = 1;
    localparam logic SW_TXOFF_RESET = 1'b0;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic SDA_LEVEL_DRIVEN = 1'b0;

    typedef enum {
        ST_IDLE, ST_DEV, ST_DEV_ACK, ST_WORD, ST_WORD_ACK,
        ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK, ST_RD_LOAD
    } two_wire_state_t;

    // live readings, big-endian, in the order they sit from MON_FIRST
    typedef struct packed {
        logic [15:0] temperature;
        logic [15:0] supply;
        logic [15:0] bias;
        logic [15:0] tx_power;
        logic [15:0] rx_power;
    } monitors_t;

    // pin-level inputs that arrive from outside the clock domain
    typedef struct packed {
        logic tx_off;
        logic tx_rate;
        logic rx_rate;
        logic fault_det;
        logic rx_lost;
        logic scl;
        logic sda;
    } pins_t;

    // transmitter off and bus idle-high as the pull-ups would leave them
    localparam pins_t PINS_RESET = 7'h43;
endpackage

// *** hw/pin_sync.sv ***
// two-flop synchroniser for the module's pin inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire optmod_pkg::pins_t i_pins,
    output optmod_pkg::pins_t o_pins
);
    optmod_pkg::pins_t meta_q;
    optmod_pkg::pins_t sync_q;

    // first stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            meta_q <= optmod_pkg::PINS_RESET;
            sync_q <= optmod_pkg::PINS_RESET;
        end else begin
            meta_q <= i_pins;
            sync_q <= meta_q;
        end
    end

    assign o_pins = sync_q;
endmodule
`default_nettype wire

// *** verification/host_bus_model.sv ***
// two-wire bus host model: bit-banged master with an open-drain data line
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_pull
);
    // clock driven high and data line released at time zero, the pull-up leaves sda high
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // data moves mid-low so the synchroniser never sees it race the clock
    task automatic bit_io(input logic b, output logic r);
        wt(4);
        o_sda_pull <= ~b;
        wt(4);
        o_scl <= 1'b1;
        wt(8);
        r = i_sda;
        o_scl <= 1'b0;
    endtask

    // start, also serves as repeated start
    task automatic start();
        wt(4);
        o_sda_pull <= 1'b0;
        wt(4);
        o_scl <= 1'b1;
        wt(8);
        o_sda_pull <= 1'b1;
        wt(8);
        o_scl <= 1'b0;
    endtask

    task automatic stop();
        wt(4);
        o_sda_pull <= 1'b1;
        wt(4);
        o_scl <= 1'b1;
        wt(8);
        o_sda_pull <= 1'b0;
        wt(8);
    endtask

    // byte out msb first, ack level back (low = acked)
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, ack);
    endtask

    // byte in msb first; last high leaves the ack released to end a read
    task automatic rd_byte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(last, r);
    endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the optical module control and status block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int TXOFF_GAP = 2000;
    localparam optmod_pkg::monitors_t MON = 80'h1234_5678_9ABC_DEF0_1357;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic tx_off = 1'b1; // pull-up level until the host drives it
    logic tx_rate = 1'b0;
    logic rx_rate = 1'b0;
    logic fault_det = 1'b0;
    logic lost_det = 1'b0;
    logic scl, sda_pull, sda_out, sda_oe, laser_en, tx_cdr, rx_cdr, fault_out, fault_oe, rx_lost;
    logic sda_w;
    int n_mismatch = 0;
    int num_checks = 0;

    // data line resolved from both open-drain parties and the pull-up
    assign sda_w = ~(sda_pull | sda_oe);
    always #5 i_clk = ~i_clk;

    optical_module_control_status i_optical_module_control_status (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_tx_off(tx_off), .i_tx_rate_sel(tx_rate),
        .i_rx_rate_sel(rx_rate), .i_laser_fault_det(fault_det), .i_receive_signal_lost_det(lost_det),
        .i_monitors(MON), .i_scl(scl), .i_sda_in(sda_w), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .o_laser_enable(laser_en), .o_tx_cdr_engage(tx_cdr), .o_rx_cdr_engage(rx_cdr),
        .o_tx_fault_out(fault_out), .o_tx_fault_oe(fault_oe), .o_receive_signal_lost(rx_lost)
    );
    host_bus_model host (.i_clk(i_clk), .i_sda(sda_w), .o_scl(scl), .o_sda_pull(sda_pull));

    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // pins need 3 edges to reach the outputs; 6 leaves margin
    task automatic settle();
        repeat (6) @(posedge i_clk);
        #1;
    endtask

    function automatic logic [7:0] stat(input int t, input int s, input int f, input int l);
        return {t[0], s[0], 3'h0, f[0], l[0], 1'b0};
    endfunction

    // the block does not time the spacing; a shortened gap keeps the run brief
    task automatic raise_tx_off();
        repeat (TXOFF_GAP) @(posedge i_clk);
        tx_off <= 1'b1;
    endtask

    task automatic drop_tx_off();
        @(posedge i_clk);
        tx_off <= 1'b0;
    endtask

    task automatic addr_phase(input logic [7:0] dev, input logic [7:0] ptr, output logic [1:0] a);
        host.start();
        host.wr_byte(dev, a[1]);
        host.wr_byte(ptr, a[0]);
    endtask

    task automatic wr1(input logic [7:0] dev, input logic [7:0] ptr, input logic [7:0] dat);
        logic [1:0] a;
        logic r;
        addr_phase(dev, ptr, a);
        host.wr_byte(dat, r);
        host.stop();
        cmp({5'h00, a, r}, 8'h00);
    endtask

    task automatic rd1(input logic [7:0] dev, input logic [7:0] ptr, output logic [7:0] dat);
        logic [1:0] a;
        logic r;
        addr_phase(dev, ptr, a);
        host.start();
        host.wr_byte(dev | 8'h01, r);
        host.rd_byte(1'b1, dat);
        host.stop();
        cmp({5'h00, a, r}, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        cmp({4'h0, sda_out, fault_out, laser_en, fault_oe}, 8'h01);
        drop_tx_off();
        settle();
        cmp({7'h00, laser_en}, 8'h01);
    endtask

    task automatic t_txoff();
        logic [7:0] d;
        rd1(8'hA2, 8'h6E, d);
        cmp(d, stat(0, 0, 0, 0));
        raise_tx_off();
        settle();
        cmp({7'h00, laser_en}, 8'h00);
        rd1(8'hA2, 8'h6E, d);
        cmp(d, stat(1, 0, 0, 0));
        drop_tx_off();
    endtask

    // all ones written: only the software off bit may take
    task automatic t_swoff();
        logic [7:0] d;
        wr1(8'hA2, 8'h6E, 8'hFF);
        settle();
        cmp({7'h00, laser_en}, 8'h00);
        rd1(8'hA2, 8'h6E, d);
        cmp(d, stat(0, 1, 0, 0));
        wr1(8'hA2, 8'h6E, 8'h00);
        settle();
        cmp({7'h00, laser_en}, 8'h01);
    endtask

    task automatic t_rates();
        for (int k = 0; k < 4; k++) begin
            @(posedge i_clk);
            tx_rate <= k[0];
            rx_rate <= k[1];
            settle();
            cmp({6'h00, rx_cdr, tx_cdr}, k[7:0]);
        end
    endtask

    task automatic t_lost();
        logic [7:0] d;
        @(posedge i_clk);
        lost_det <= 1'b1;
        settle();
        cmp({7'h00, rx_lost}, 8'h01);
        rd1(8'hA2, 8'h6E, d);
        cmp(d, stat(0, 0, 0, 1));
        @(posedge i_clk);
        lost_det <= 1'b0;
        settle();
        cmp({7'h00, rx_lost}, 8'h00);
    endtask

    // short fault pulse must stay latched until the off pin is cycled
    task automatic t_fault();
        logic [7:0] d;
        @(posedge i_clk);
        fault_det <= 1'b1;
        repeat (4) @(posedge i_clk);
        fault_det <= 1'b0;
        settle();
        cmp({6'h00, laser_en, ~fault_oe}, 8'h01);
        rd1(8'hA2, 8'h6E, d);
        cmp(d, stat(0, 0, 1, 0));
        raise_tx_off();
        settle();
        cmp({6'h00, laser_en, ~fault_oe}, 8'h00);
        drop_tx_off();
        settle();
        cmp({7'h00, laser_en}, 8'h01);
    endtask

    // pointer wraps from byte 255 to byte 0 inside one write
    task automatic t_memory();
        logic [7:0] d;
        logic [1:0] a;
        logic r;
        addr_phase(8'hA0, 8'hFF, a);
        host.wr_byte(8'h5A, r);
        host.wr_byte(8'hC3, r);
        host.stop();
        cmp({5'h00, a, r}, 8'h00);
        wr1(8'hA2, 8'h00, 8'h96);
        rd1(8'hA0, 8'hFF, d);
        cmp(d, 8'h5A);
        rd1(8'hA0, 8'h00, d);
        cmp(d, 8'hC3);
        rd1(8'hA2, 8'h00, d);
        cmp(d, 8'h96);
        host.start();
        host.wr_byte(8'hA4, r);
        host.stop();
        cmp({7'h00, r}, 8'h01);
    endtask

    // monitor bytes ignore writes and read back big-endian in one burst
    task automatic t_monitors();
        logic [7:0] d;
        logic [1:0] a;
        logic r;
        wr1(8'hA2, 8'h60, 8'h00);
        addr_phase(8'hA2, 8'h60, a);
        host.start();
        host.wr_byte(8'hA3, r);
        for (int k = 0; k < 10; k++) begin
            host.rd_byte(k == 9, d);
            cmp(d, MON[79 - 8 * k -: 8]);
        end
        host.stop();
        cmp({5'h00, a, r}, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // main sequence; reset held two edges, every flop but the memory arrays resets synchronously
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        settle();
        t_reset();
        t_txoff();
        t_swoff();
        t_rates();
        t_lost();
        t_fault();
        t_memory();
        t_monitors();
        tally_and_finish();
    end

    // watchdog: the sequence needs roughly 14k cycles
    initial begin
        repeat (40000) @(posedge i_clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
